/* ctms_pkg.sv */
// constants and state record for the tag maintenance and statistics block
// assumes an AXI4-Lite master with 32-bit data and word-aligned accesses
package ctms_pkg;
	localparam int unsigned AW = 8;
	localparam int unsigned DW = 32;
	localparam int unsigned FW = 3;

	localparam logic [AW-1:0] OFF_MODE    = 8'h00;
	localparam logic [AW-1:0] OFF_BANK    = 8'h0C;
	localparam logic [AW-1:0] OFF_CMD     = 8'h10;
	localparam logic [AW-1:0] OFF_FADDR   = 8'h14;
	localparam logic [AW-1:0] OFF_FLAGS   = 8'h20;
	localparam logic [AW-1:0] OFF_ISTAT   = 8'h28;
	localparam logic [AW-1:0] OFF_IMASK   = 8'h2C;
	localparam logic [AW-1:0] OFF_HIT_HI  = 8'h40;
	localparam logic [AW-1:0] OFF_HIT_LO  = 8'h44;
	localparam logic [AW-1:0] OFF_MISS_HI = 8'h50;
	localparam logic [AW-1:0] OFF_MISS_LO = 8'h54;
	localparam logic [AW-1:0] OFF_FILL_HI = 8'h60;
	localparam logic [AW-1:0] OFF_FILL_LO = 8'h64;

	localparam int unsigned CMD_ALLOC = 0;
	localparam int unsigned CMD_LOCK  = 1;
	localparam int unsigned CMD_FILL  = 2;
	localparam int unsigned CMD_INVAL = 3;
	localparam int unsigned FLG_ALLOC = 0;
	localparam int unsigned FLG_INVAL = 1;
	localparam int unsigned FLG_ERR   = 2;
	localparam int unsigned MODE_SRST = 1;
	localparam int unsigned BANK_HI   = 24;

	localparam logic [1:0]    RESP_OKAY   = 2'h0;
	localparam logic [1:0]    RESP_SLVERR = 2'h2;
	localparam logic [DW-1:0] REG_RST     = 32'h0000_0000;

	typedef struct packed {
		logic          aw_v;
		logic [AW-1:0] aw_a;
		logic          w_v;
		logic [DW-1:0] w_d;
		logic [3:0]    w_s;
		logic          b_v;
		logic [1:0]    b_r;
		logic          r_v;
		logic [DW-1:0] r_d;
		logic [1:0]    r_r;
		logic [DW-1:0] bank;
		logic [DW-1:0] faddr;
		logic [FW-1:0] flags;
		logic [FW-1:0] istat;
		logic [FW-1:0] imask;
		logic          irq;
		logic [63:0]   hit;
		logic [63:0]   miss;
		logic [63:0]   fill;
		logic [3:0]    cmd;
		logic [DW-1:0] flash_a;
		logic [DW-1:0] tag_a;
	} ctms_state_t;
endpackage

/* ctms_top.sv */
// tag maintenance commands, event flags and hit/miss/fill counters
// assumes: AXI4-Lite master, far-side cache FSM gives one-cycle event pulses
`timescale 1ns/1ps
module ctms_top (
	input  wire logic        CORE_CLK_I,
	input  wire logic        RST_I,
	input  wire logic        CE_I,
	input  wire logic [7:0]  S_AXI_AWADDR_I,
	input  wire logic        S_AXI_AWVALID_I,
	output logic             S_AXI_AWREADY_O,
	input  wire logic [31:0] S_AXI_WDATA_I,
	input  wire logic [3:0]  S_AXI_WSTRB_I,
	input  wire logic        S_AXI_WVALID_I,
	output logic             S_AXI_WREADY_O,
	output logic [1:0]       S_AXI_BRESP_O,
	output logic             S_AXI_BVALID_O,
	input  wire logic        S_AXI_BREADY_I,
	input  wire logic [7:0]  S_AXI_ARADDR_I,
	input  wire logic        S_AXI_ARVALID_I,
	output logic             S_AXI_ARREADY_O,
	output logic [31:0]      S_AXI_RDATA_O,
	output logic [1:0]       S_AXI_RRESP_O,
	output logic             S_AXI_RVALID_O,
	input  wire logic        S_AXI_RREADY_I,
	input  wire logic        ADDR24_I,
	input  wire logic        HIT_I,
	input  wire logic        MISS_I,
	input  wire logic        FILL_DONE_I,
	input  wire logic        ALLOC_DONE_I,
	input  wire logic        INVAL_DONE_I,
	input  wire logic        FLASH_ERR_I,
	output logic             CMD_ALLOC_O,
	output logic             CMD_FILL_O,
	output logic             CMD_LOCK_O,
	output logic             CMD_INVAL_O,
	output logic [31:0]      TAG_ADDR_O,
	output logic [31:0]      FLASH_ADDR_O,
	output logic             IRQ_O
);
	ctms_pkg::ctms_state_t q_r;
	ctms_pkg::ctms_state_t q_nxt;
	ctms_pkg::ctms_state_t keep;
	logic                  aw_go;
	logic                  w_go;
	logic                  ar_go;
	logic                  wr_go;
	logic                  srst_go;
	logic [32:0]           rd;
	logic [31:0]           bank_eff;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] s);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				m[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return m;
	endfunction

	// write to either half loads it, else count the event; write wins
	function automatic logic [63:0] count(input logic [63:0] v,
		input logic ev, input logic wh, input logic wl,
		input logic [31:0] d, input logic [3:0] s);
		logic [63:0] c;
		c = v;
		if (wh || wl) begin
			if (wh) begin
				c[63:32] = merge(v[63:32], d, s);
			end
			if (wl) begin
				c[31:0] = merge(v[31:0], d, s);
			end
		end else if (ev) begin
			c = v + 64'h0000_0000_0000_0001;
		end
		return c;
	endfunction

	// {error, data}; reserved and write-only bits read back as zero
	function automatic logic [32:0] rmux(input ctms_pkg::ctms_state_t s,
		input logic [7:0] a);
		logic [32:0] r;
		r = {1'b0, ctms_pkg::REG_RST};
		case (a)
		ctms_pkg::OFF_MODE:    r[31:0] = ctms_pkg::REG_RST;
		ctms_pkg::OFF_BANK:    r[31:0] = s.bank;
		ctms_pkg::OFF_CMD:     r[31:0] = ctms_pkg::REG_RST;
		ctms_pkg::OFF_FADDR:   r[31:0] = s.faddr;
		ctms_pkg::OFF_FLAGS:   r[2:0] = s.flags;
		ctms_pkg::OFF_ISTAT:   r[2:0] = s.istat;
		ctms_pkg::OFF_IMASK:   r[2:0] = s.imask;
		ctms_pkg::OFF_HIT_HI:  r[31:0] = s.hit[63:32];
		ctms_pkg::OFF_HIT_LO:  r[31:0] = s.hit[31:0];
		ctms_pkg::OFF_MISS_HI: r[31:0] = s.miss[63:32];
		ctms_pkg::OFF_MISS_LO: r[31:0] = s.miss[31:0];
		ctms_pkg::OFF_FILL_HI: r[31:0] = s.fill[63:32];
		ctms_pkg::OFF_FILL_LO: r[31:0] = s.fill[31:0];
		default:               r[32] = 1'b1;
		endcase
		return r;
	endfunction

	// no channel is taken while the block is frozen
	assign S_AXI_AWREADY_O = CE_I & ~q_r.aw_v & ~q_r.b_v;
	assign S_AXI_WREADY_O  = CE_I & ~q_r.w_v & ~q_r.b_v;
	assign S_AXI_ARREADY_O = CE_I & ~q_r.r_v;
	assign aw_go   = S_AXI_AWVALID_I & S_AXI_AWREADY_O;
	assign w_go    = S_AXI_WVALID_I & S_AXI_WREADY_O;
	assign ar_go   = S_AXI_ARVALID_I & S_AXI_ARREADY_O;
	assign wr_go   = q_r.aw_v & q_r.w_v & ~q_r.b_v;
	assign srst_go = wr_go & (q_r.aw_a == ctms_pkg::OFF_MODE)
		& q_r.w_s[0] & q_r.w_d[ctms_pkg::MODE_SRST];
	assign rd      = rmux(q_r, S_AXI_ARADDR_I);

	// upper bank byte dropped for 24-bit flash
	always_comb begin
		bank_eff = q_r.bank;
		if (ADDR24_I) begin
			bank_eff[31:ctms_pkg::BANK_HI] = 8'h00;
		end
	end

	always_comb begin
		logic       wb;
		logic [7:0] wa;
		logic [2:0] clr;
		logic [32:0] wm;
		wb    = wr_go;
		wa    = q_r.aw_a;
		clr   = 3'h0;
		wm    = rmux(q_r, q_r.aw_a);
		q_nxt = q_r;
		keep  = q_r;
		if (aw_go) begin
			q_nxt.aw_v = 1'b1;
			q_nxt.aw_a = S_AXI_AWADDR_I;
		end
		if (w_go) begin
			q_nxt.w_v = 1'b1;
			q_nxt.w_d = S_AXI_WDATA_I;
			q_nxt.w_s = S_AXI_WSTRB_I;
		end
		if (q_r.b_v && S_AXI_BREADY_I) begin
			q_nxt.b_v = 1'b0;
		end
		if (q_r.r_v && S_AXI_RREADY_I) begin
			q_nxt.r_v = 1'b0;
		end
		q_nxt.cmd = 4'h0;
		if (wb) begin
			q_nxt.aw_v = 1'b0;
			q_nxt.w_v  = 1'b0;
			q_nxt.b_v  = 1'b1;
			q_nxt.b_r  = wm[32] ? ctms_pkg::RESP_SLVERR
				: ctms_pkg::RESP_OKAY;
			if (wa == ctms_pkg::OFF_BANK) begin
				q_nxt.bank = merge(q_r.bank, q_r.w_d, q_r.w_s);
			end
			if (wa == ctms_pkg::OFF_FADDR) begin
				q_nxt.faddr = merge(q_r.faddr, q_r.w_d, q_r.w_s);
			end
			if (wa == ctms_pkg::OFF_IMASK && q_r.w_s[0]) begin
				q_nxt.imask = q_r.w_d[2:0];
			end
			// only bits 2:0 clear, rest ignored
			if (wa == ctms_pkg::OFF_FLAGS && q_r.w_s[0]) begin
				clr = q_r.w_d[2:0];
			end
			if (wa == ctms_pkg::OFF_CMD && q_r.w_s[0]) begin
				q_nxt.cmd[ctms_pkg::CMD_ALLOC] =
					q_r.w_d[ctms_pkg::CMD_ALLOC];
				q_nxt.cmd[ctms_pkg::CMD_FILL] =
					q_r.w_d[ctms_pkg::CMD_FILL]
					& q_r.w_d[ctms_pkg::CMD_ALLOC];
				q_nxt.cmd[ctms_pkg::CMD_LOCK] =
					q_r.w_d[ctms_pkg::CMD_LOCK]
					& q_r.w_d[ctms_pkg::CMD_ALLOC];
				q_nxt.cmd[ctms_pkg::CMD_INVAL] =
					q_r.w_d[ctms_pkg::CMD_INVAL];
				q_nxt.tag_a   = q_r.faddr;
				q_nxt.flash_a = q_r.faddr | bank_eff;
			end
		end
		// error flag, set wins over clear
		q_nxt.flags[ctms_pkg::FLG_ERR] = FLASH_ERR_I
			| (q_r.flags[ctms_pkg::FLG_ERR] & ~clr[ctms_pkg::FLG_ERR]);
		q_nxt.flags[ctms_pkg::FLG_INVAL] = INVAL_DONE_I
			| (q_r.flags[ctms_pkg::FLG_INVAL] & ~clr[ctms_pkg::FLG_INVAL]);
		q_nxt.flags[ctms_pkg::FLG_ALLOC] = ALLOC_DONE_I
			| (q_r.flags[ctms_pkg::FLG_ALLOC] & ~clr[ctms_pkg::FLG_ALLOC]);
		// interrupt status: read clears, a same-cycle event still sets
		q_nxt.istat = {FLASH_ERR_I, INVAL_DONE_I, ALLOC_DONE_I}
			| (ar_go && S_AXI_ARADDR_I == ctms_pkg::OFF_ISTAT
			? 3'h0 : q_r.istat);
		q_nxt.hit  = count(q_r.hit, HIT_I,
			wb && wa == ctms_pkg::OFF_HIT_HI,
			wb && wa == ctms_pkg::OFF_HIT_LO, q_r.w_d, q_r.w_s);
		q_nxt.miss = count(q_r.miss, MISS_I,
			wb && wa == ctms_pkg::OFF_MISS_HI,
			wb && wa == ctms_pkg::OFF_MISS_LO, q_r.w_d, q_r.w_s);
		q_nxt.fill = count(q_r.fill, FILL_DONE_I,
			wb && wa == ctms_pkg::OFF_FILL_HI,
			wb && wa == ctms_pkg::OFF_FILL_LO, q_r.w_d, q_r.w_s);
		if (ar_go) begin
			q_nxt.r_v = 1'b1;
			q_nxt.r_d = rd[31:0];
			q_nxt.r_r = rd[32] ? ctms_pkg::RESP_SLVERR
				: ctms_pkg::RESP_OKAY;
		end
		// soft reset keeps only the bus handshake in flight
		if (srst_go) begin
			keep  = q_nxt;
			q_nxt = '0;
			q_nxt.b_v = keep.b_v;
			q_nxt.b_r = keep.b_r;
			q_nxt.r_v = keep.r_v;
			q_nxt.r_d = keep.r_d;
			q_nxt.r_r = keep.r_r;
		end
		q_nxt.irq = |(q_nxt.istat & q_nxt.imask);
	end

	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			q_r <= '0;
		end else if (CE_I) begin
			q_r <= q_nxt;
		end
	end

	assign S_AXI_BVALID_O = q_r.b_v;
	assign S_AXI_BRESP_O  = q_r.b_r;
	assign S_AXI_RVALID_O = q_r.r_v;
	assign S_AXI_RDATA_O  = q_r.r_d;
	assign S_AXI_RRESP_O  = q_r.r_r;
	assign CMD_ALLOC_O    = q_r.cmd[ctms_pkg::CMD_ALLOC];
	assign CMD_FILL_O     = q_r.cmd[ctms_pkg::CMD_FILL];
	assign CMD_LOCK_O     = q_r.cmd[ctms_pkg::CMD_LOCK];
	assign CMD_INVAL_O    = q_r.cmd[ctms_pkg::CMD_INVAL];
	assign TAG_ADDR_O     = q_r.tag_a;
	assign FLASH_ADDR_O   = q_r.flash_a;
	assign IRQ_O          = q_r.irq;

	logic cmd_wr;
	assign cmd_wr = wr_go & CE_I & ~srst_go
		& (q_r.aw_a == ctms_pkg::OFF_CMD) & q_r.w_s[0];

	// flag register write that takes effect this cycle
	logic flg_wr;
	assign flg_wr = wr_go & CE_I & ~srst_go
		& (q_r.aw_a == ctms_pkg::OFF_FLAGS) & q_r.w_s[0];

	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (RST_I);

	a_inval_issue: assert property (
		cmd_wr && q_r.w_d[ctms_pkg::CMD_INVAL] |=> CMD_INVAL_O
	) else $error("invalidate not issued");
	a_fill_gated: assert property (
		CMD_FILL_O |-> CMD_ALLOC_O
	) else $error("fill without allocate");
	a_lock_follows: assert property (
		cmd_wr && q_r.w_d[ctms_pkg::CMD_LOCK]
		&& q_r.w_d[ctms_pkg::CMD_ALLOC] |=> CMD_LOCK_O && CMD_ALLOC_O
	) else $error("lock not issued");
	a_alloc_pulse: assert property (
		cmd_wr && q_r.w_d[ctms_pkg::CMD_ALLOC] |=> CMD_ALLOC_O ##1
		!CMD_ALLOC_O
	) else $error("allocate not one pulse");
	a_flash_addr: assert property (
		CMD_ALLOC_O |-> FLASH_ADDR_O == ($past(q_r.faddr) | $past(bank_eff))
	) else $error("flash address wrong");
	a_err_sticky: assert property (
		CE_I && !srst_go && FLASH_ERR_I |=> q_r.flags[ctms_pkg::FLG_ERR]
	) else $error("error flag not set");
	a_inval_done: assert property (
		CE_I && !srst_go && INVAL_DONE_I |=> q_r.flags[ctms_pkg::FLG_INVAL]
	) else $error("invalidate flag not set");
	a_alloc_done: assert property (
		CE_I && !srst_go && ALLOC_DONE_I |=> q_r.flags[ctms_pkg::FLG_ALLOC]
	) else $error("allocate flag not set");
	a_hit_step: assert property (
		CE_I && HIT_I && !wr_go |=> q_r.hit == $past(q_r.hit) + 64'h1
	) else $error("hit count did not step");
	a_srst_clear: assert property (
		srst_go && CE_I |=> q_r.hit == 64'h0 && q_r.flags == 3'h0
		&& q_r.bank == 32'h0
	) else $error("soft reset left state");
	a_fill_issue: assert property (
		cmd_wr && q_r.w_d[ctms_pkg::CMD_FILL]
		&& q_r.w_d[ctms_pkg::CMD_ALLOC] |=> CMD_FILL_O
	) else $error("fill not issued");
	a_lock_clear: assert property (
		cmd_wr && !q_r.w_d[ctms_pkg::CMD_LOCK] |=> !CMD_LOCK_O
	) else $error("lock issued unasked");
	a_lock_gated: assert property (
		CMD_LOCK_O |-> CMD_ALLOC_O
	) else $error("lock without allocate");
	a_alloc_gate: assert property (
		cmd_wr && !q_r.w_d[ctms_pkg::CMD_ALLOC]
		|=> !CMD_ALLOC_O && !CMD_FILL_O && !CMD_LOCK_O
	) else $error("command without allocate");
	a_inval_zero: assert property (
		cmd_wr && !q_r.w_d[ctms_pkg::CMD_INVAL] |=> !CMD_INVAL_O
	) else $error("invalidate issued unasked");
	a_tag_addr: assert property (
		CMD_ALLOC_O |-> TAG_ADDR_O == $past(q_r.faddr)
	) else $error("tag address wrong");
	a_err_clear: assert property (
		flg_wr && q_r.w_d[ctms_pkg::FLG_ERR] && !FLASH_ERR_I
		|=> !q_r.flags[ctms_pkg::FLG_ERR]
	) else $error("error flag not cleared");
	a_inval_hold: assert property (
		q_r.flags[ctms_pkg::FLG_INVAL] && !srst_go
		&& !(flg_wr && q_r.w_d[ctms_pkg::FLG_INVAL])
		|=> q_r.flags[ctms_pkg::FLG_INVAL]
	) else $error("invalidate flag lost");
	a_alloc_hold: assert property (
		q_r.flags[ctms_pkg::FLG_ALLOC] && !srst_go
		&& !(flg_wr && q_r.w_d[ctms_pkg::FLG_ALLOC])
		|=> q_r.flags[ctms_pkg::FLG_ALLOC]
	) else $error("allocate flag lost");
	a_miss_step: assert property (
		CE_I && MISS_I && !wr_go |=> q_r.miss == $past(q_r.miss) + 64'h1
	) else $error("miss count did not step");
	a_fill_step: assert property (
		CE_I && FILL_DONE_I && !wr_go
		|=> q_r.fill == $past(q_r.fill) + 64'h1
	) else $error("fill count did not step");
	a_hlo_load: assert property (
		wr_go && CE_I && q_r.aw_a == ctms_pkg::OFF_HIT_LO && &q_r.w_s
		|=> q_r.hit[31:0] == $past(q_r.w_d)
	) else $error("hit low half not loaded");
	a_mhi_load: assert property (
		wr_go && CE_I && q_r.aw_a == ctms_pkg::OFF_MISS_HI && &q_r.w_s
		|=> q_r.miss[63:32] == $past(q_r.w_d)
	) else $error("miss high half not loaded");
	a_fhi_load: assert property (
		wr_go && CE_I && q_r.aw_a == ctms_pkg::OFF_FILL_HI && &q_r.w_s
		|=> q_r.fill[63:32] == $past(q_r.w_d)
	) else $error("fill high half not loaded");

	c_cmd_write: cover property (cmd_wr ##1 CMD_ALLOC_O);
	c_read_done: cover property (S_AXI_RVALID_O && S_AXI_RREADY_I);
	c_irq_up:    cover property (!IRQ_O ##1 IRQ_O);
	c_soft_rst:  cover property (srst_go);
	c_fill_cmd:  cover property (CMD_FILL_O);
endmodule

/* ctms_far_model.sv */
// far-side cache state machine: answers forced commands with done pulses
// assumes one-cycle command pulses from the block on the same clock
`timescale 1ns/1ps
module ctms_far_model #(
	parameter int DLY = 3
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic alloc_i,
	input  wire logic fill_i,
	input  wire logic inval_i,
	output logic      alloc_done_o,
	output logic      fill_done_o,
	output logic      inval_done_o
);
	logic [DLY-1:0] a_r;
	logic [DLY-1:0] f_r;
	logic [DLY-1:0] i_r;

	// fill follows only a forwarded fill
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			a_r <= '0;
			f_r <= '0;
			i_r <= '0;
		end else begin
			a_r <= {a_r[DLY-2:0], alloc_i};
			f_r <= {f_r[DLY-2:0], fill_i};
			i_r <= {i_r[DLY-2:0], inval_i};
		end
	end
	// one done pulse per request, never merged
	assign alloc_done_o = a_r[DLY-1];
	assign fill_done_o  = f_r[DLY-1];
	assign inval_done_o = i_r[DLY-1];
endmodule

/* cache_tag_maint_and_stats_bench.sv */
// self-checking bench for the tag maintenance and statistics block
// assumes ctms_top and the far-side model on one 40 MHz clock
`timescale 1ns/1ps
module cache_tag_maint_and_stats_bench;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        ce = 1'b1;
	logic        addr24 = 1'b0;
	logic [2:0]  ev = 3'h0;
	logic [7:0]  awaddr = 8'h00;
	logic [7:0]  araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'hF;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0]  bresp, rresp, resp_v;
	logic [31:0] rdata, tag_a, fl_a, rd_v;
	logic        c_al, c_fi, c_lo, c_in, d_al, d_fi, d_in;
	logic [3:0]  cmd_v;
	int          error_cnt = 0;
	int          num_checks = 0;

	ctms_top uut (
		.CORE_CLK_I(clk), .RST_I(rst), .CE_I(ce),
		.S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
		.S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
		.S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid),
		.S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp),
		.S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
		.S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
		.S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
		.S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
		.S_AXI_RREADY_I(rready), .ADDR24_I(addr24), .HIT_I(ev[0]),
		.MISS_I(ev[1]), .FILL_DONE_I(d_fi), .ALLOC_DONE_I(d_al),
		.INVAL_DONE_I(d_in), .FLASH_ERR_I(ev[2]), .CMD_ALLOC_O(c_al),
		.CMD_FILL_O(c_fi), .CMD_LOCK_O(c_lo), .CMD_INVAL_O(c_in),
		.TAG_ADDR_O(tag_a), .FLASH_ADDR_O(fl_a), .IRQ_O(irq)
	);

	ctms_far_model #(.DLY(3)) far (
		.clk_i(clk), .rst_i(rst), .alloc_i(c_al), .fill_i(c_fi),
		.inval_i(c_in), .alloc_done_o(d_al), .fill_done_o(d_fi),
		.inval_done_o(d_in)
	);

	initial begin
		forever #12.5 clk = ~clk;
	end

	task automatic test_done();
		if (error_cnt == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic tmo(input logic ok);
		if (!ok) begin
			error_cnt++;
			test_done();
		end
	endtask

	// command pulses are sampled together with bvalid
	// bready and rready stay up between transfers, so back-to-back
	// calls never lower and raise them in one time step
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		logic ok;
		n = 0;
		ok = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!ok && n < 40) begin
			@(posedge clk);
			n++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin
				ok = 1'b1;
				resp_v = bresp;
				cmd_v = {c_in, c_fi, c_lo, c_al};
			end
		end
		tmo(ok);
	endtask

	task automatic rd(input logic [7:0] a);
		int n;
		logic ok;
		n = 0;
		ok = 1'b0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!ok && n < 40) begin
			@(posedge clk);
			n++;
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				ok = 1'b1;
				rd_v = rdata;
				resp_v = rresp;
			end
		end
		tmo(ok);
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(rd_v, e);
	endtask

	task automatic poll(input logic [7:0] a, input logic [31:0] e);
		int n;
		n = 0;
		rd(a);
		while (rd_v !== e && n < 20) begin
			rd(a);
			n++;
		end
		chk(rd_v, e);
	endtask

	task automatic pulse(input logic [2:0] v, input int n);
		repeat (n) begin
			ev <= v;
			@(posedge clk);
			ev <= 3'h0;
			@(posedge clk);
		end
	endtask

	task automatic t_reset();
		logic [7:0] m [13] = '{8'h00, 8'h0C, 8'h10, 8'h14, 8'h20, 8'h28,
			8'h2C, 8'h40, 8'h44, 8'h50, 8'h54, 8'h60, 8'h64};
		foreach (m[i]) rc(m[i], 32'h0);
		rc(8'h30, 32'h0);
		chk(32'(resp_v), 32'(ctms_pkg::RESP_SLVERR));
		wr(8'h34, 32'h1);
		chk(32'(resp_v), 32'(ctms_pkg::RESP_SLVERR));
	endtask

	task automatic t_alloc();
		wr(8'h0C, 32'hAB10_0000);
		wr(8'h14, 32'h0000_1234);
		wr(8'h10, 32'hFFFF_FFF6);
		chk(32'(cmd_v), 32'h0);
		wr(8'h10, 32'h0);
		chk(32'(cmd_v), 32'h0);
		wr(8'h10, 32'h7);
		chk(32'(cmd_v), 32'h7);
		chk(tag_a, 32'h0000_1234);
		chk(fl_a, 32'hAB10_1234);
		poll(8'h20, 32'h1);
		rc(8'h10, 32'h0);
		rc(8'h64, 32'h1);
		wr(8'h20, 32'h0);
		rc(8'h20, 32'h1);
		wr(8'h20, 32'h1);
		rc(8'h20, 32'h0);
		addr24 <= 1'b1;
		wr(8'h10, 32'h5);
		chk(32'(cmd_v), 32'h5);
		chk(fl_a, 32'h0010_1234);
		poll(8'h20, 32'h1);
		rc(8'h64, 32'h2);
		wr(8'h20, 32'h1);
	endtask

	task automatic t_inval();
		wr(8'h10, 32'h8);
		chk(32'(cmd_v), 32'h8);
		poll(8'h20, 32'h2);
		wr(8'h20, 32'h2);
		rc(8'h20, 32'h0);
	endtask

	task automatic t_err();
		pulse(3'h4, 1);
		rc(8'h20, 32'h4);
		wr(8'h20, 32'hFFFF_FFFB);
		rc(8'h20, 32'h4);
		wr(8'h20, 32'h4);
		rc(8'h20, 32'h0);
	endtask

	task automatic t_count();
		pulse(3'h1, 3);
		pulse(3'h2, 2);
		rc(8'h44, 32'h3);
		rc(8'h54, 32'h2);
		wr(8'h44, 32'hFFFF_FFFF);
		pulse(3'h1, 1);
		rc(8'h40, 32'h1);
		rc(8'h44, 32'h0);
		// a frozen block records no events
		ce <= 1'b0;
		pulse(3'h1, 2);
		ce <= 1'b1;
		rc(8'h44, 32'h0);
		wr(8'h50, 32'h5);
		rc(8'h50, 32'h5);
		wr(8'h60, 32'h7);
		rc(8'h60, 32'h7);
		wstrb <= 4'h2;
		wr(8'h60, 32'h0000_5500);
		rc(8'h60, 32'h0000_5507);
		wstrb <= 4'hF;
	endtask

	// istat holds earlier events, so it is read clear first
	task automatic t_irq();
		rd(8'h28);
		wr(8'h2C, 32'h0);
		pulse(3'h4, 1);
		@(posedge clk);
		chk({31'h0, irq}, 32'h0);
		rc(8'h28, 32'h4);
		wr(8'h2C, 32'h4);
		pulse(3'h4, 1);
		@(posedge clk);
		chk({31'h0, irq}, 32'h1);
		rc(8'h28, 32'h4);
		repeat (3) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
	endtask

	task automatic t_srst();
		wr(8'h00, 32'h2);
		rc(8'h40, 32'h0);
		rc(8'h50, 32'h0);
		rc(8'h60, 32'h0);
		rc(8'h14, 32'h0);
		rc(8'h0C, 32'h0);
		rc(8'h20, 32'h0);
		rc(8'h2C, 32'h0);
		rc(8'h00, 32'h0);
	endtask

	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_alloc();
		t_inval();
		t_err();
		t_count();
		t_irq();
		t_srst();
		test_done();
	end
endmodule
